// File: verilog/usb_out_ep_device.sv
// Behaviour
// RQ1 - write one clears toggle; bit reads zero
// RQ2 - stall handshake sets sticky stall-sent flag
// RQ3 - stall-request bit held by software, honoured live
// RQ4 - isochronous mode ignores stall-request
// RQ5 - flush drops head packet, clears ready
// RQ6 - flush bit self-clears; one packet per flush
// RQ7 - software avoids flushing a partly read packet
// RQ8 - isochronous crc error sets data-error flag
// RQ9 - clearing ready also clears data-error
// RQ10 - isochronous packet lost when full sets overrun
// RQ11 - full means slots used equal capacity
// RQ12 - packet available sets ready, pulses interrupt
// RQ13 - software clears ready after unloading packet
// RQ14 - double buffer bit selects one or two slots
// RQ15 - iso bit selects bulk or isochronous mode
// RQ16 - unused high control bits read zero
// RQ17 - ten bit count split low and high
// RQ18 - count trusted only while ready reads one
// RQ19 - stalling answers every out with interrupt
// RQ20 - second waiting packet re-raises ready, interrupt
// RQ21 - bad isochronous packet still loaded and flagged
// RQ22 - write zero clears sticky flags, one ignored
`timescale 1ns/1ps
`default_nettype none
module usb_out_ep_device
  import usb_out_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // usb link
  usb_out_link_if.device         link,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // fifo unload port
  output logic                   rd_valid_o,
  input  wire logic              rd_ready_i,
  output logic      [BYTE_W-1:0] rd_data_o,
  output logic                   rd_last_o,
  // endpoint interrupt
  output logic                   ep_irq_o
);
  typedef enum {L_IDLE, L_DATA, L_HS} link_state_e;
  typedef enum {D_IDLE, D_FLUSH, D_DROP} drain_state_e;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  link_state_e        link_state_reg;
  drain_state_e       drain_state_reg;
  logic               toggle_reg, stall_sent_reg, stall_req_reg, flush_reg, data_err_reg;
  logic               overrun_reg, ready_reg, dbl_reg, iso_reg, drop_reg;
  hs_code_e           hs_reg;
  logic [COUNT_W-1:0] cnt_reg;
  // packet slot queue, oldest at rd_slot_reg
  logic [COUNT_W-1:0] slot_cnt [SLOTS_MAX];
  logic               slot_good [SLOTS_MAX];
  logic               slot_err [SLOTS_MAX];
  logic               wr_slot_reg, rd_slot_reg;
  logic [1:0]         used_reg;
  // ----------------------------------------------------------------
  // decode and data path
  // ----------------------------------------------------------------
  logic               wr_low, wr_high, full, stall_eff, head_valid, sw_clr_ready;
  logic               flush_start, drain_last, slot_pop, slot_push, tok_take, byte_take;
  logic               ready_set, fifo_in_ready, fifo_out_valid;
  logic [FIFO_WORD_W-1:0] fifo_out;
  logic [COUNT_W-1:0] head_cnt;
  assign wr_low     = reg_wr_i && (reg_addr_i == OFS_CTRL_LOW);
  assign wr_high    = reg_wr_i && (reg_addr_i == OFS_CTRL_HIGH);
  assign full       = (used_reg >= (dbl_reg ? 2'd2 : 2'd1)); // RQ11 RQ14
  assign stall_eff  = stall_req_reg && !iso_reg; // RQ3 RQ4
  assign head_valid = (used_reg != 2'd0);
  assign sw_clr_ready = wr_low && !reg_wdata_i[BIT_PKT_READY] && ready_reg
                      && (drain_state_reg == D_IDLE) && !reg_wdata_i[BIT_FLUSH];
  assign flush_start  = wr_low && reg_wdata_i[BIT_FLUSH] && head_valid
                      && (drain_state_reg == D_IDLE);
  assign drain_last = (drain_state_reg != D_IDLE) && fifo_out_valid
                    && fifo_out[FIFO_WORD_W-1];
  assign slot_pop   = sw_clr_ready || drain_last;
  assign tok_take   = (link_state_reg == L_IDLE) && link.tok_valid;
  assign byte_take  = (link_state_reg == L_DATA) && link.byte_valid && link.byte_ready;
  assign slot_push  = byte_take && link.byte_last && !drop_reg;
  // a flush in the cycle a packet comes up wins, so ready never outlives it
  assign ready_set  = (drain_state_reg == D_IDLE) && head_valid && !flush_start
                    && slot_good[rd_slot_reg] && !ready_reg; // RQ12 RQ20
  // discarded packets are still consumed so the host never hangs
  assign link.byte_ready = (link_state_reg == L_DATA) && (drop_reg || fifo_in_ready);
  assign link.hs_valid   = (link_state_reg == L_HS);
  assign link.hs_code    = hs_reg;
  assign rd_valid_o      = fifo_out_valid && (drain_state_reg == D_IDLE);
  assign rd_data_o       = fifo_out[BYTE_W-1:0];
  assign rd_last_o       = fifo_out[FIFO_WORD_W-1];
  usb_out_fifo #(
    .WIDTH (FIFO_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  ((link_state_reg == L_DATA) && link.byte_valid && !drop_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({link.byte_last, link.byte_data}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i ((drain_state_reg != D_IDLE) || rd_ready_i),
    .out_data_o  (fifo_out)
  );
  // ----------------------------------------------------------------
  // link side: token, data, handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      link_state_reg <= L_IDLE;
      drop_reg       <= 1'b0;
      hs_reg         <= HS_NONE;
      cnt_reg        <= '0;
    end else begin
      case (link_state_reg)
        L_IDLE: begin
          if (tok_take) begin
            link_state_reg <= L_DATA;
            cnt_reg        <= '0;
            if (iso_reg) begin
              drop_reg <= full; // RQ10
              hs_reg   <= HS_NONE;
            end else if (stall_eff) begin
              drop_reg <= 1'b1; // RQ19
              hs_reg   <= HS_STALL;
            end else if (full) begin
              drop_reg <= 1'b1;
              hs_reg   <= HS_NAK;
            end else begin
              // a repeated packet is acknowledged but not stored
              drop_reg <= (link.tok_pid != toggle_reg);
              hs_reg   <= HS_ACK;
            end
          end
        end
        L_DATA: begin
          if (byte_take) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (link.byte_last) begin
              link_state_reg <= L_HS;
              if (!iso_reg && !drop_reg && link.byte_crc_err) begin
                hs_reg <= HS_NONE;
              end
            end
          end
        end
        default: link_state_reg <= L_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // packet slots and drain engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (slot_push) begin
      slot_cnt[wr_slot_reg]  <= cnt_reg + 1'b1; // RQ17
      slot_good[wr_slot_reg] <= iso_reg || !link.byte_crc_err; // RQ21
      slot_err[wr_slot_reg]  <= iso_reg && link.byte_crc_err; // RQ8
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_slot_reg     <= 1'b0;
      rd_slot_reg     <= 1'b0;
      used_reg        <= 2'd0;
      drain_state_reg <= D_IDLE;
      flush_reg       <= 1'b0;
    end else begin
      if (slot_push) wr_slot_reg <= ~wr_slot_reg;
      if (slot_pop) rd_slot_reg <= ~rd_slot_reg;
      used_reg <= used_reg + {1'b0, slot_push} - {1'b0, slot_pop};
      case (drain_state_reg)
        D_IDLE: begin
          if (flush_start) begin
            drain_state_reg <= D_FLUSH; // RQ5
            flush_reg       <= 1'b1;
          end else if (head_valid && !slot_good[rd_slot_reg]) begin
            drain_state_reg <= D_DROP;
          end
        end
        default: begin
          if (drain_last) begin
            drain_state_reg <= D_IDLE;
            flush_reg       <= 1'b0; // RQ6
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // status flags, interrupt and register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ready_reg    <= 1'b0;
      data_err_reg <= 1'b0;
      ep_irq_o     <= 1'b0;
    end else begin
      ep_irq_o <= ready_set
               || (tok_take && iso_reg && full)
               || (link.hs_valid && (hs_reg == HS_STALL)); // RQ19
      if (ready_set) begin
        ready_reg    <= 1'b1; // RQ12
        data_err_reg <= slot_err[rd_slot_reg];
      end else if (sw_clr_ready || flush_start) begin
        ready_reg    <= 1'b0; // RQ13 RQ5
        data_err_reg <= 1'b0; // RQ9
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stall_sent_reg <= 1'b0;
      overrun_reg    <= 1'b0;
      stall_req_reg  <= 1'b0;
      toggle_reg     <= 1'b0;
      dbl_reg        <= 1'b0;
      iso_reg        <= 1'b0;
    end else begin
      // a hardware set in the same cycle as a clear wins
      if (link.hs_valid && (hs_reg == HS_STALL)) begin
        stall_sent_reg <= 1'b1; // RQ2
      end else if (wr_low && !reg_wdata_i[BIT_STALL_SENT]) begin
        stall_sent_reg <= 1'b0; // RQ22
      end
      if (tok_take && iso_reg && full) begin
        overrun_reg <= 1'b1; // RQ10
      end else if (wr_low && !reg_wdata_i[BIT_OVERRUN]) begin
        overrun_reg <= 1'b0; // RQ22
      end
      if (wr_low) stall_req_reg <= reg_wdata_i[BIT_STALL_REQ]; // RQ3
      if (wr_low && reg_wdata_i[BIT_CLEAR_TOGGLE]) begin
        toggle_reg <= 1'b0; // RQ1
      end else if (slot_push && !iso_reg && !link.byte_crc_err) begin
        toggle_reg <= ~toggle_reg;
      end
      if (wr_high) begin
        dbl_reg <= reg_wdata_i[BIT_DOUBLE_BUF]; // RQ14
        iso_reg <= reg_wdata_i[BIT_ISO]; // RQ15
      end
    end
  end
  assign head_cnt = head_valid ? slot_cnt[rd_slot_reg] : '0;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= REG_RESET;
    end else if (reg_rd_i) begin
      if (reg_addr_i == OFS_CTRL_LOW) begin
        reg_rdata_o <= {1'b0, stall_sent_reg, stall_req_reg, flush_reg, // RQ1
                        data_err_reg, overrun_reg, full, ready_reg};
      end else if (reg_addr_i == OFS_CTRL_HIGH) begin
        reg_rdata_o <= {dbl_reg, iso_reg, 6'h00}; // RQ16
      end else if (reg_addr_i == OFS_CNT_LOW) begin
        reg_rdata_o <= head_cnt[7:0]; // RQ17
      end else if (reg_addr_i == OFS_CNT_HIGH) begin
        reg_rdata_o <= {6'h00, head_cnt[9:8]}; // RQ17
      end else begin
        reg_rdata_o <= REG_RESET;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/usb_out_pkg.sv
package usb_out_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_LOW  = 8'h14;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h15;
  localparam logic [7:0] OFS_CNT_LOW   = 8'h16;
  localparam logic [7:0] OFS_CNT_HIGH  = 8'h17;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // out_endpoint_control_low bit positions
  localparam int BIT_CLEAR_TOGGLE = 7;
  localparam int BIT_STALL_SENT   = 6;
  localparam int BIT_STALL_REQ    = 5;
  localparam int BIT_FLUSH        = 4;
  localparam int BIT_DATA_ERROR   = 3;
  localparam int BIT_OVERRUN      = 2;
  localparam int BIT_FIFO_FULL    = 1;
  localparam int BIT_PKT_READY    = 0;
  // out_endpoint_control_high bit positions
  localparam int BIT_DOUBLE_BUF   = 7;
  localparam int BIT_ISO          = 6;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int COUNT_W        = 10;
  localparam int BYTE_W         = 8;
  localparam int FIFO_WORD_W    = 9;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int SLOTS_MAX      = 2;

  typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_code_e;
endpackage

// File: verilog/usb_out_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usb_out_link_if;
  import usb_out_pkg::*;
  logic                tok_valid;
  logic                tok_pid;
  logic                byte_valid;
  logic                byte_ready;
  logic [BYTE_W-1:0]   byte_data;
  logic                byte_last;
  logic                byte_crc_err;
  logic                hs_valid;
  hs_code_e            hs_code;

  modport device (
    input  tok_valid, tok_pid, byte_valid, byte_data, byte_last, byte_crc_err,
    output byte_ready, hs_valid, hs_code
  );
  modport host (
    output tok_valid, tok_pid, byte_valid, byte_data, byte_last, byte_crc_err,
    input  byte_ready, hs_valid, hs_code
  );
endinterface
`default_nettype wire

// File: verilog/usb_out_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module usb_out_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // refused at elaboration: the pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
  assign in_ready_o  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                     || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/usb_out_ep_host.sv
`timescale 1ns/1ps
`default_nettype none
module usb_out_ep_host
  import usb_out_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // usb link
  usb_out_link_if.host           link,
  // packet source
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  input  wire logic [BYTE_W-1:0] tx_data_i,
  input  wire logic              tx_last_i,
  input  wire logic              tx_pid_i,
  input  wire logic              tx_crc_err_i,
  // result
  output logic                   done_o,
  output hs_code_e               hs_code_o
);
  typedef enum {H_IDLE, H_DATA, H_WAIT} host_state_e;
  host_state_e state_reg;

  assign link.tok_valid    = (state_reg == H_IDLE) && tx_valid_i;
  assign link.tok_pid      = tx_pid_i;
  assign link.byte_valid   = (state_reg == H_DATA) && tx_valid_i;
  assign link.byte_data    = tx_data_i;
  assign link.byte_last    = tx_last_i;
  assign link.byte_crc_err = tx_crc_err_i;
  assign tx_ready_o        = (state_reg == H_DATA) && link.byte_ready;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= H_IDLE;
      done_o    <= 1'b0;
      hs_code_o <= HS_NONE;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (tx_valid_i) begin
            state_reg <= H_DATA;
          end
        end
        H_DATA: begin
          if (tx_valid_i && link.byte_ready && tx_last_i) begin
            state_reg <= H_WAIT;
          end
        end
        default: begin
          if (link.hs_valid) begin
            state_reg <= H_IDLE;
            done_o    <= 1'b1;
            hs_code_o <= link.hs_code;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/usb_out_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module usb_out_monitor
  import usb_out_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // link signals
  input  wire logic              tok_valid,
  input  wire logic              tok_pid,
  input  wire logic              byte_valid,
  input  wire logic              byte_ready,
  input  wire logic [BYTE_W-1:0] byte_data,
  input  wire logic              byte_last,
  input  wire logic              byte_crc_err,
  input  wire hs_code_e          hs_code,
  input  wire logic              hs_valid
);
  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  wire logic took_last;
  assign took_last = byte_valid && byte_ready && byte_last;

  hs_answer_a: assert property (took_last |=> hs_valid)
    else $error("no handshake one cycle after last byte");
  hs_cause_a: assert property (hs_valid |-> $past(took_last))
    else $error("handshake without a closing byte");
  hs_pulse_a: assert property (hs_valid |=> !hs_valid)
    else $error("handshake longer than one cycle");
  offer_hold_a: assert property (byte_valid && !byte_ready |=>
    byte_valid && $stable(byte_data) && $stable(byte_last))
    else $error("refused byte not held");
  pid_steady_a: assert property ($past(byte_valid) && byte_valid |-> $stable(tok_pid))
    else $error("data pid changed inside a packet");
  quiet_after_a: assert property (took_last |=> !byte_valid [*2])
    else $error("byte offered before handshake completed");
  hs_alone_a: assert property (hs_valid |-> !tok_valid && !byte_valid)
    else $error("handshake overlaps host traffic");
  token_first_a: assert property ($rose(byte_valid) |-> $past(tok_valid))
    else $error("packet bytes without a token");
endmodule
`default_nettype wire

// File: dv/usb_out_endpoint_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usb_out_endpoint_control_bench
  import usb_out_pkg::*;
;
  logic       clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_valid_o, rd_ready_i, rd_last_o;
  logic       ep_irq_o, tx_valid_i, tx_ready_o, tx_last_i, tx_pid_i, tx_crc_err_i, done_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_data_o, tx_data_i, rv;
  logic [7:0] sent[$];
  hs_code_e   hs_code_o, hs;
  int         errors, checks, cycles, dones, irqs, i0, n, m;

  usb_out_link_if usb_out_link_if_i ();
  usb_out_ep_device #(.FIFO_DEPTH(8)) usb_out_ep_device_i (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .link(usb_out_link_if_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .rd_data_o(rd_data_o), .rd_last_o(rd_last_o), .ep_irq_o(ep_irq_o));
  usb_out_ep_host usb_out_ep_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .link(usb_out_link_if_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_pid_i(tx_pid_i),
    .tx_crc_err_i(tx_crc_err_i), .done_o(done_o), .hs_code_o(hs_code_o));
  usb_out_monitor usb_out_monitor_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .tok_valid(usb_out_link_if_i.tok_valid), .tok_pid(usb_out_link_if_i.tok_pid),
    .byte_valid(usb_out_link_if_i.byte_valid), .byte_ready(usb_out_link_if_i.byte_ready),
    .byte_data(usb_out_link_if_i.byte_data), .byte_last(usb_out_link_if_i.byte_last),
    .byte_crc_err(usb_out_link_if_i.byte_crc_err), .hs_code(usb_out_link_if_i.hs_code),
    .hs_valid(usb_out_link_if_i.hs_valid));

  // ----------------------------------------------------------------
  // clock, watchdog, event counters
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // pulses are counted here so a short one is never missed by a task
  always @(posedge clk_sys_i) begin
    cycles++;
    if (done_o === 1'b1) dones++;
    if (ep_irq_o === 1'b1) irqs++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_hs(input hs_code_e got, input hs_code_e exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: handshake %s expected %s", $time, got.name(), exp.name());
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    check_byte(reg_rdata_o, exp);
  endtask

  // one packet through the host end; keep=1 records bytes the device must store
  task automatic send(input int len, input bit pid, input bit crc, input bit keep,
                      output hs_code_e h);
    int k;
    int d0;
    d0 = dones;
    for (k = 0; k < len; k++) begin
      @(negedge clk_sys_i);
      tx_valid_i = 1'b1;
      tx_data_i = 8'($urandom);
      tx_last_i = (k == len - 1);
      tx_pid_i = pid;
      tx_crc_err_i = crc;
      if (keep) sent.push_back(tx_data_i);
      #1;
      while (tx_ready_o !== 1'b1) begin
        @(negedge clk_sys_i);
        #1;
      end
    end
    @(negedge clk_sys_i);
    tx_valid_i = 1'b0;
    for (k = 0; k < 100 && dones == d0; k++) @(negedge clk_sys_i);
    h = hs_code_o;
  endtask

  task automatic unload(input int len);
    int k;
    int j;
    for (k = 0; k < len; k++) begin
      @(negedge clk_sys_i);
      for (j = 0; j < 50 && rd_valid_o !== 1'b1; j++) @(negedge clk_sys_i);
      check_byte(rd_data_o, sent.pop_front());
      check_byte({7'h00, rd_last_o}, {7'h00, k == len - 1});
      rd_ready_i = 1'b1;
      @(negedge clk_sys_i);
      rd_ready_i = 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {reg_wr_i, reg_rd_i, rd_ready_i, tx_valid_i, tx_last_i, tx_pid_i, tx_crc_err_i} = '0;
    {reg_addr_i, reg_wdata_i, tx_data_i} = '0;
    sys_rst_i = 1'b1;
    void'($urandom(72));
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    sent.delete();
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h20, 8'h00);
    reg_wr(8'h15, 8'hFF);
    rd_chk(8'h15, 8'hC0);
    reg_wr(8'h15, 8'h00);
    $display("test register map done");
    // single slot: one packet fills it, the next is refused
    i0 = irqs;
    n = 1 + $urandom % 4;
    send(n, 1'b0, 1'b0, 1'b1, hs);
    check_hs(hs, HS_ACK);
    rd_chk(8'h14, 8'h03);
    rd_chk(8'h16, n[7:0]);
    check_byte(8'(irqs - i0), 8'h01);
    send(2, 1'b1, 1'b0, 1'b0, hs);
    check_hs(hs, HS_NAK);
    unload(n);
    reg_wr(8'h14, 8'h00);
    rd_chk(8'h14, 8'h00);
    reg_wr(8'h14, 8'h80);
    rd_chk(8'h14, 8'h00);
    $display("test single buffer done");
    // double buffer: second packet comes up after the first is released
    reg_wr(8'h15, 8'h80);
    i0 = irqs;
    n = 1 + $urandom % 4;
    m = 1 + $urandom % 4;
    send(n, 1'b0, 1'b0, 1'b1, hs);
    check_hs(hs, HS_ACK);
    rd_chk(8'h14, 8'h01);
    send(m, 1'b1, 1'b0, 1'b1, hs);
    check_hs(hs, HS_ACK);
    rd_chk(8'h14, 8'h03);
    rd_chk(8'h16, n[7:0]);
    unload(n);
    reg_wr(8'h14, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    rd_chk(8'h14, 8'h01);
    rd_chk(8'h16, m[7:0]);
    check_byte(8'(irqs - i0), 8'h02);
    reg_wr(8'h14, 8'h10);
    repeat (20) @(negedge clk_sys_i);
    rd_chk(8'h14, 8'h00);
    repeat (m) void'(sent.pop_front());
    reg_wr(8'h14, 8'h10);
    rd_chk(8'h14, 8'h00);
    $display("test double buffer and flush done");
    // stall on a bulk endpoint, toggle left alone
    i0 = irqs;
    reg_wr(8'h14, 8'h20);
    send(2, 1'b0, 1'b0, 1'b0, hs);
    check_hs(hs, HS_STALL);
    send(3, 1'b0, 1'b0, 1'b0, hs);
    check_hs(hs, HS_STALL);
    rd_chk(8'h14, 8'h60);
    check_byte(8'(irqs - i0), 8'h02);
    reg_wr(8'h14, 8'h20);
    rd_chk(8'h14, 8'h20);
    reg_wr(8'h14, 8'h40);
    rd_chk(8'h14, 8'h00);
    send(1, 1'b0, 1'b0, 1'b1, hs);
    check_hs(hs, HS_ACK);
    unload(1);
    reg_wr(8'h14, 8'h00);
    $display("test stall done");
    // isochronous: stall ignored, bad packet kept, overrun on a full fifo
    reg_wr(8'h15, 8'hC0);
    reg_wr(8'h14, 8'hA0);
    n = 1 + $urandom % 4;
    m = 1 + $urandom % 4;
    send(n, 1'b0, 1'b1, 1'b1, hs);
    check_hs(hs, HS_NONE);
    rd_chk(8'h14, 8'h29);
    send(m, 1'b0, 1'b1, 1'b1, hs);
    rd_chk(8'h14, 8'h2B);
    send(2, 1'b0, 1'b0, 1'b0, hs);
    rd_chk(8'h14, 8'h2F);
    unload(n);
    reg_wr(8'h14, 8'h24);
    repeat (3) @(negedge clk_sys_i);
    rd_chk(8'h14, 8'h2D);
    unload(m);
    reg_wr(8'h14, 8'h20);
    rd_chk(8'h14, 8'h20);
    $display("test isochronous done");
    complete_run();
  end
endmodule
`default_nettype wire
